// File: hdl/ddr_cmd_state.sv
// Purpose: command decode, bank states, cke power states, write burst window
// Assumes: command pins are synchronous to ref_clk_in; registers on avalon-mm
// Notes: controller timing misuse is flagged in a sticky error register
//
// Overview of operation
// - write-to-read check applies whatever bank the read targets.
// - data after a precharge truncating a burst is ignored.
// - precharge closes rows; banks idle again only after row precharge time.
// - a10 high precharges all banks; low precharges the bank on ba.
// - cke low with no access enters precharge or active power-down.
// - power-down switches off input and output buffers.
// - cke high at edge n exits power-down; commands from edge n+1.
// - cke previous and current samples select power state changes.
// - cs, ras, cas and we decode into commands on each edge.
// - a read truncating a write stops further data from being stored.
`timescale 1ns/1ps
module ddr_cmd_state (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // command pins
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [ddr_ctl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [ddr_ctl_pkg::BA_W-1:0] ba_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // device status
  output logic in_buf_en_out,
  output logic out_buf_en_out,
  output logic wr_data_en_out,
  output logic [ddr_ctl_pkg::NUM_BANKS-1:0] bank_open_out
);
  import ddr_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    if (cs_n) begin
      return CMD_INHIBIT;
    end
    unique case ({ras_n, cas_n, we_n})
      3'b111: return CMD_NOP;
      3'b011: return CMD_ACTIVE;
      3'b001: return CMD_AREF;
      3'b000: return CMD_MRS;
      3'b101: return CMD_READ;
      3'b100: return CMD_WRITE;
      3'b010: return CMD_PRE;
      3'b110: return CMD_BST;
    endcase
  endfunction

  pwr_state_t pwr_q, pwr_d;
  bank_state_t bank_st [NUM_BANKS];
  logic cke_prev_q;
  logic [1:0] bl_q;
  logic [2:0] wr_left_q, wr_left_d;
  logic [CNT_W-1:0] wtr_cnt_q, wtr_cnt_d, wr_cnt_q, wr_cnt_d, xsr_cnt_q;
  logic [ERR_W-1:0] err_q, err_set;
  logic wait_q;
  logic [31:0] rdata_q;

  // commands count only with cke high at both samples in normal state
  cmd_t cmd;
  wire cmd_ok = cke_prev_q & cke_in & (pwr_q == PWR_NORMAL);
  wire act_ok = cmd_ok & (cmd == CMD_ACTIVE);
  wire rd_ok = cmd_ok & (cmd == CMD_READ);
  wire wr_ok = cmd_ok & (cmd == CMD_WRITE);
  wire pre_ok = cmd_ok & (cmd == CMD_PRE);
  wire [NUM_BANKS-1:0] ba_hit = NUM_BANKS'(1) << ba_in;
  wire [NUM_BANKS-1:0] pre_mask = addr_in[A10_BIT] ? '1 : ba_hit;
  wire [2:0] bl_pairs = 3'(1) << (bl_q - 2'h1);
  wire wburst = (wr_left_q != '0);
  wire last_pair = (wr_left_q == 3'h1) & ~(rd_ok | pre_ok);
  assign cmd = decode_cmd(cs_n_in, ras_n_in, cas_n_in, we_n_in);

  ////////////////////////////////////////////////////////////////////////
  // banks
  logic [NUM_BANKS-1:0] bank_idle, bank_active;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      ddr_bank_fsm u_bank (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .act_in(act_ok & ba_hit[gi]),
        .pre_in(pre_ok & pre_mask[gi]),
        .state_out(bank_st[gi])
      );
      assign bank_idle[gi] = (bank_st[gi] == BANK_IDLE);
      assign bank_active[gi] = (bank_st[gi] == BANK_ACTIVE);
    end
  endgenerate
  wire all_idle = &bank_idle;

  ////////////////////////////////////////////////////////////////////////
  // power state from the cke sample pair
  wire cke_fall = cke_prev_q & ~cke_in;
  wire cke_rise = ~cke_prev_q & cke_in;
  wire quiet = (cmd == CMD_NOP) | (cmd == CMD_INHIBIT);
  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_NORMAL: if (cke_fall) begin
        if (cmd == CMD_AREF && all_idle) begin
          pwr_d = PWR_SELF_REF;
        end else if (quiet && !wburst) begin
          pwr_d = all_idle ? PWR_PRE_PD : PWR_ACT_PD;
        end
      end
      PWR_PRE_PD, PWR_ACT_PD: if (cke_rise) begin
        pwr_d = PWR_NORMAL;
      end
      PWR_SELF_REF: if (cke_rise) begin
        pwr_d = PWR_SR_EXIT;
      end
      PWR_SR_EXIT: if (xsr_cnt_q == '0) begin
        pwr_d = PWR_NORMAL;
      end
      default: begin
        pwr_d = PWR_NORMAL;
      end
    endcase
  end

  // write burst window; truncation closes it so later data is dropped
  always_comb begin
    wr_left_d = wburst ? wr_left_q - 3'h1 : 3'h0;
    if (wr_ok) begin
      wr_left_d = bl_pairs;
    end else if (rd_ok | pre_ok) begin
      wr_left_d = 3'h0;
    end
    wtr_cnt_d = (wtr_cnt_q == '0) ? '0 : wtr_cnt_q - 1'b1;
    wr_cnt_d = (wr_cnt_q == '0) ? '0 : wr_cnt_q - 1'b1;
    if (last_pair) begin
      wtr_cnt_d = T_WTR_CYC;
      wr_cnt_d = T_WR_CYC;
    end
  end

  // controller misuse; not exhaustive, only cheap cases
  assign err_set[ERR_WTR] = rd_ok & (wtr_cnt_q != '0);
  assign err_set[ERR_WR] = pre_ok & (wr_cnt_q != '0);
  assign err_set[ERR_NOT_ACT] = (rd_ok | wr_ok) & ~|(ba_hit & bank_active);

  // core state registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pwr_q <= PWR_NORMAL;
      cke_prev_q <= 1'b0;
      wr_left_q <= 3'h0;
      wtr_cnt_q <= '0;
      wr_cnt_q <= '0;
      xsr_cnt_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      cke_prev_q <= cke_in;
      wr_left_q <= wr_left_d;
      wtr_cnt_q <= wtr_cnt_d;
      wr_cnt_q <= wr_cnt_d;
      xsr_cnt_q <= (pwr_d == PWR_SR_EXIT && pwr_q != PWR_SR_EXIT) ?
                   T_XSR_CYC - 1'b1 : (xsr_cnt_q == '0 ? '0 : xsr_cnt_q - 1'b1);
    end
  end

  // registered outputs; buffers off in any low-power state
  wire buf_on = (pwr_d == PWR_NORMAL) | (pwr_d == PWR_SR_EXIT);
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      in_buf_en_out <= 1'b1;
      out_buf_en_out <= 1'b1;
      wr_data_en_out <= 1'b0;
      bank_open_out <= '0;
    end else begin
      in_buf_en_out <= buf_on;
      out_buf_en_out <= buf_on;
      wr_data_en_out <= (wr_left_d != 3'h0);
      bank_open_out <= ~bank_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer at the edge waitrequest is low
  wire req = avs_read_in | avs_write_in;
  wire wr_take = avs_write_in & ~wait_q & avs_byteenable_in[0];
  wire [31:0] stat_word = {19'h0, wburst, ~bank_idle[3:0] & 4'hF,
                           3'h0, pwr_q};
  wire [31:0] rd_mux = (avs_address_in == OFS_CTRL) ? {30'h0, bl_q} :
                       (avs_address_in == OFS_STATUS) ? stat_word :
                       (avs_address_in == OFS_ERR) ? {29'h0, err_q} : 32'h0;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~(req & wait_q);
      rdata_q <= (avs_read_in & wait_q) ? rd_mux : rdata_q;
    end
  end
  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;

  // ctrl holds burst length code; code 0 is kept as a burst of 2
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bl_q <= CTRL_RST;
    end else if (wr_take && avs_address_in == OFS_CTRL) begin
      bl_q <= (avs_writedata_in[1:0] == 2'h0) ? 2'h1 : avs_writedata_in[1:0];
    end
  end

  // sticky errors, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      err_q <= '0;
    end else begin
      err_q <= (err_q & ~((wr_take && avs_address_in == OFS_ERR) ?
                          avs_writedata_in[ERR_W-1:0] : '0)) | err_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_in_pd;
    pwr_q == PWR_PRE_PD || pwr_q == PWR_ACT_PD;
  endsequence
  sequence s_wake;
    pwr_q == PWR_NORMAL ##0 in_buf_en_out;
  endsequence

  chk_trunc_pre_data: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (pre_ok && wburst) |=> !wr_data_en_out && !wburst)
    else $error("data window still open after precharge truncation");

  chk_trunc_rd_data: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    rd_ok |=> !wr_data_en_out)
    else $error("data window still open after read truncation");

  chk_pre_all_banks: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (pre_ok && addr_in[A10_BIT]) |=> bank_active == '0)
    else $error("precharge all left a row open");

  chk_pd_flavour: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (pwr_q == PWR_NORMAL && cke_fall && quiet && !wburst) |=>
      pwr_q == ($past(all_idle) ? PWR_PRE_PD : PWR_ACT_PD))
    else $error("wrong power-down flavour");

  chk_pd_buffers: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    s_in_pd |-> !in_buf_en_out && !out_buf_en_out)
    else $error("buffers on during power-down");

  chk_pd_exit_next: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    s_in_pd ##0 cke_in |=> s_wake)
    else $error("power-down exit not ready for next edge");

  chk_cmd_gating: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (!cke_prev_q || pwr_q != PWR_NORMAL) |-> !(act_ok || rd_ok || wr_ok || pre_ok))
    else $error("command accepted without cke high twice");

  chk_wtr_flag: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (rd_ok && wtr_cnt_q != '0) |=> err_q[ERR_WTR])
    else $error("early read not flagged");

  chk_burst_length: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_ok && bl_q == 2'h2) |=> wr_data_en_out [*2] ##1 1'b1)
    else $error("burst of four window wrong length");

endmodule // ddr_cmd_state

// File: pkg/ddr_ctl_pkg.sv
// Purpose: shared constants and types for the ddr command/bank-state block
// Assumes: 20 MHz core clock, commands sampled on its rising edge
// Notes: times are in ns; cycle counts are derived from them
package ddr_ctl_pkg;

  // clock and timing, least times rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RP_NS = 20;
  localparam int T_RCD_NS = 20;
  localparam int T_WR_NS = 15;
  localparam int T_WTR_NS = 50;
  localparam int T_XSR_NS = 75;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] T_RP_CYC =
    CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_RCD_CYC =
    CNT_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_WR_CYC =
    CNT_W'((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_WTR_CYC =
    CNT_W'((T_WTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_XSR_CYC =
    CNT_W'((T_XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // pins
  localparam int ADDR_W = 13;
  localparam int A10_BIT = 10;
  localparam int BA_W = 2;
  localparam int NUM_BANKS = 4;

  // register map (byte addresses) and fields
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_ERR = 4'h8;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam int STAT_PWR_LSB = 0;
  localparam int STAT_OPEN_LSB = 8;
  localparam int STAT_WBURST_BIT = 12;
  localparam int ERR_WTR = 0;
  localparam int ERR_WR = 1;
  localparam int ERR_NOT_ACT = 2;
  localparam int ERR_W = 3;

  // decoded commands
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0, CMD_NOP = 4'h1, CMD_ACTIVE = 4'h2, CMD_READ = 4'h3,
    CMD_WRITE = 4'h4, CMD_BST = 4'h5, CMD_PRE = 4'h6, CMD_AREF = 4'h7,
    CMD_MRS = 4'h8
  } cmd_t;

  // per-bank state
  typedef enum logic [3:0] {
    BANK_IDLE = 4'b0001, BANK_ACTIVATING = 4'b0010,
    BANK_ACTIVE = 4'b0100, BANK_PRECHARGING = 4'b1000
  } bank_state_t;

  // global power state
  typedef enum logic [4:0] {
    PWR_NORMAL = 5'b00001, PWR_PRE_PD = 5'b00010, PWR_ACT_PD = 5'b00100,
    PWR_SELF_REF = 5'b01000, PWR_SR_EXIT = 5'b10000
  } pwr_state_t;

endpackage

// File: hdl/ddr_bank_fsm.sv
// Purpose: one bank's row state with activate and precharge timing
// Assumes: act_in and pre_in are already qualified commands for this bank
// Notes: precharge of an idle bank is a no-op
`timescale 1ns/1ps
module ddr_bank_fsm (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // commands
  input wire logic act_in,
  input wire logic pre_in,
  // state
  output ddr_ctl_pkg::bank_state_t state_out
);
  import ddr_ctl_pkg::*;

  bank_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // next state; timer counts the remaining activate or precharge cycles
  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q == '0) ? '0 : cnt_q - 1'b1;
    unique case (st_q)
      BANK_IDLE: if (act_in) begin
        st_d = BANK_ACTIVATING;
        cnt_d = T_RCD_CYC - 1'b1;
      end
      BANK_ACTIVATING: if (cnt_q == '0) begin
        st_d = BANK_ACTIVE;
      end
      BANK_ACTIVE: if (pre_in) begin
        st_d = BANK_PRECHARGING;
        cnt_d = T_RP_CYC - 1'b1;
      end
      BANK_PRECHARGING: if (cnt_q == '0) begin
        st_d = BANK_IDLE;
      end
      default: begin
        st_d = BANK_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= BANK_IDLE;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign state_out = st_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_precharging;
    st_q == BANK_PRECHARGING;
  endsequence
  sequence s_back_idle;
    st_q == BANK_IDLE;
  endsequence

  chk_pre_closes_row: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (st_q == BANK_ACTIVE && pre_in) |=> s_precharging ##1 s_back_idle)
    else $error("precharge did not close the row in time");

  chk_act_opens_row: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (st_q == BANK_IDLE && act_in) |=>
      st_q == BANK_ACTIVATING ##1 st_q == BANK_ACTIVE)
    else $error("activate did not open the row in time");

endmodule // ddr_bank_fsm

// File: verif/ddr_ctl_model.sv
// Purpose: memory controller model that drives the command pins
// Assumes: the bench calls issue once per command; only the bench sets the gaps
// Notes: pins return to nop after each command; the address shows its inverse
`timescale 1ns/1ps
module ddr_ctl_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // command pins
  output logic cke_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [ddr_ctl_pkg::ADDR_W-1:0] addr_out,
  output logic [ddr_ctl_pkg::BA_W-1:0] ba_out
);
  import ddr_ctl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // idle pins at time zero: cke high, nop
  initial begin
    cke_out = 1'b1;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h7;
    addr_out = '0;
    ba_out = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one command on the next edge, then nop for gap cycles
  // gap gives write-to-read and write recovery waits
  // gap gives the row precharge wait before a new activate
  // gap gives at least two nops through self-refresh exit
  // cke keeps its last value, so power-down holds it low
  // power-down in the bench lasts a few cycles, far below refresh
  // only inhibit, nop, activate, read, write, precharge and refresh are sent
  // no dll disable and no strobe pins are modelled here
  task automatic issue(input logic [3:0] pins, input logic [ADDR_W-1:0] a,
                       input logic [BA_W-1:0] b, input logic ke, input int gap);
    @(posedge ref_clk_in);
    cke_out <= ke;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= pins;
    addr_out <= a;
    ba_out <= b;
    @(posedge ref_clk_in);
    // a released address must not keep the last value
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h7;
    addr_out <= ~a;
    ba_out <= ~b;
    repeat (gap) @(posedge ref_clk_in);
  endtask
endmodule // ddr_ctl_model

// File: verif/ddr_cmd_state_test.sv
// Purpose: self-checking bench for the command and bank-state block
// Assumes: 20 MHz clock; ddr_ctl_model drives the command pins
// Notes: registers are reached over avalon-mm with waitrequest
`timescale 1ns/1ps
module ddr_cmd_state_test;
  import ddr_ctl_pkg::*;
  localparam logic [3:0] P_NOP = 4'h7;
  localparam logic [3:0] P_ACT = 4'h3;
  localparam logic [3:0] P_RD = 4'h5;
  localparam logic [3:0] P_WR = 4'h4;
  localparam logic [3:0] P_PRE = 4'h2;
  localparam logic [3:0] P_REF = 4'h1;
  localparam logic [ADDR_W-1:0] A_ALL = 13'h0400;
  logic ref_clk_in, sys_rst_in, cke, cs_n, ras_n, cas_n, we_n;
  logic avs_read, avs_write, waitreq, in_buf, out_buf, wr_en;
  logic [ADDR_W-1:0] addr;
  logic [BA_W-1:0] ba;
  logic [3:0] avs_address, avs_be;
  logic [31:0] avs_wdata, avs_rdata, rd;
  logic [NUM_BANKS-1:0] bank_open;
  int failures = 0;
  int compares = 0;
  int wr_cnt = 0;
  int n0;

  //////////////////////////////////////////////////////////////////////////////
  // block under test and controller model
  ddr_cmd_state i_ddr_cmd_state (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .cke_in(cke),
    .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
    .addr_in(addr), .ba_in(ba), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_byteenable_in(avs_be),
    .avs_writedata_in(avs_wdata), .avs_readdata_out(avs_rdata),
    .avs_waitrequest_out(waitreq), .in_buf_en_out(in_buf),
    .out_buf_en_out(out_buf), .wr_data_en_out(wr_en), .bank_open_out(bank_open));
  ddr_ctl_model i_ddr_ctl_model (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .cke_out(cke),
    .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
    .addr_out(addr), .ba_out(ba));

  // 50 ns clock
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // running count of write-window cycles; read as differences so no race
  always @(posedge ref_clk_in) wr_cnt <= wr_cnt + int'(wr_en === 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus access
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // request held until waitrequest is sampled low; bounded wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_be <= be;
    avs_wdata <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = avs_rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 4'hF, 32'h0, rd);
    check(nm, rd, exp);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'hF, d, rd);
  endtask

  task automatic cmd(input logic [3:0] p, input logic [ADDR_W-1:0] a,
                     input logic [BA_W-1:0] b, input logic k, input int g);
    i_ddr_ctl_model.issue(p, a, b, k, g);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rreg(OFS_CTRL, 32'h2, "ctrl");
    rreg(OFS_STATUS, 32'h1, "status");
    rreg(OFS_ERR, 32'h0, "err");
    rreg(4'hC, 32'h0, "unmapped");
    bus(1'b1, OFS_CTRL, 4'h0, 32'h3, rd);
    rreg(OFS_CTRL, 32'h2, "ctrl lane off");
    wreg(OFS_STATUS, 32'hFF);
    rreg(OFS_STATUS, 32'h1, "status ro");
    check("in_buf", 32'(in_buf), 32'h1);
    $display("done reset");
  endtask

  task automatic t_decode();
    cmd(4'hB, '0, 2'h0, 1'b1, 3);
    check("inhibit", 32'(bank_open), 32'h0);
    cmd(P_ACT, '0, 2'h0, 1'b1, 3);
    check("open b0", 32'(bank_open), 32'h1);
    cmd(P_RD, '0, 2'h0, 1'b1, 2);
    rreg(OFS_ERR, 32'h0, "rd active");
    cmd(P_RD, '0, 2'h2, 1'b1, 2);
    rreg(OFS_ERR, 32'h4, "rd idle");
    wreg(OFS_ERR, 32'h7);
    rreg(OFS_ERR, 32'h0, "err clear");
    $display("done decode");
  endtask

  // window length follows the burst length code
  task automatic t_burst();
    for (int c = 1; c < 4; c++) begin
      wreg(OFS_CTRL, 32'(c));
      n0 = wr_cnt;
      cmd(P_WR, '0, 2'h0, 1'b1, 8);
      check("window", 32'(wr_cnt - n0), 32'(1 << (c - 1)));
    end
    cmd(P_WR, '0, 2'h0, 1'b1, 0);
    rreg(OFS_STATUS, 32'h1101, "wburst");
    wreg(OFS_CTRL, 32'h0);
    rreg(OFS_CTRL, 32'h1, "bl zero");
    $display("done burst");
  endtask

  // a burst of 8 cut after two pairs by read, then by precharge
  task automatic t_trunc();
    wreg(OFS_CTRL, 32'h3);
    n0 = wr_cnt;
    cmd(P_WR, '0, 2'h0, 1'b1, 0);
    cmd(P_RD, '0, 2'h0, 1'b1, 8);
    check("rd cut", 32'(wr_cnt - n0), 32'h2);
    n0 = wr_cnt;
    cmd(P_WR, '0, 2'h0, 1'b1, 0);
    cmd(P_PRE, '0, 2'h0, 1'b1, 8);
    check("pre cut", 32'(wr_cnt - n0), 32'h2);
    check("b0 closed", 32'(bank_open), 32'h0);
    wreg(OFS_ERR, 32'h7);
    $display("done trunc");
  endtask

  task automatic t_turn();
    wreg(OFS_CTRL, 32'h2);
    cmd(P_ACT, '0, 2'h0, 1'b1, 2);
    cmd(P_ACT, '0, 2'h1, 1'b1, 2);
    cmd(P_WR, '0, 2'h0, 1'b1, 6);
    cmd(P_RD, '0, 2'h1, 1'b1, 2);
    cmd(P_WR, '0, 2'h0, 1'b1, 6);
    cmd(P_PRE, '0, 2'h0, 1'b1, 3);
    rreg(OFS_ERR, 32'h0, "no err");
    check("pre b0", 32'(bank_open), 32'h2);
    cmd(P_ACT, '0, 2'h0, 1'b1, 2);
    cmd(P_ACT, '0, 2'h2, 1'b1, 2);
    cmd(P_PRE, '0, 2'h1, 1'b1, 3);
    check("pre b1", 32'(bank_open), 32'h5);
    // read and precharge one edge too early after the last pair
    cmd(P_WR, '0, 2'h0, 1'b1, 1);
    cmd(P_RD, '0, 2'h2, 1'b1, 2);
    rreg(OFS_ERR, 32'h1, "early rd");
    cmd(P_WR, '0, 2'h0, 1'b1, 1);
    cmd(P_PRE, '0, 2'h0, 1'b1, 3);
    rreg(OFS_ERR, 32'h3, "early pre");
    wreg(OFS_ERR, 32'h3);
    rreg(OFS_ERR, 32'h0, "err clear 2");
    cmd(P_PRE, A_ALL, 2'h1, 1'b1, 3);
    check("pre all", 32'(bank_open), 32'h0);
    $display("done turn");
  endtask

  task automatic t_pwr();
    cmd(P_NOP, '0, 2'h0, 1'b0, 3);
    check("in_buf pd", 32'(in_buf), 32'h0);
    check("out_buf pd", 32'(out_buf), 32'h0);
    rreg(OFS_STATUS, 32'h2, "pre pd");
    cmd(P_ACT, '0, 2'h0, 1'b0, 2);
    check("pd ignore", 32'(bank_open), 32'h0);
    cmd(P_NOP, '0, 2'h0, 1'b1, 2);
    check("in_buf up", 32'(in_buf), 32'h1);
    rreg(OFS_STATUS, 32'h1, "pd exit");
    cmd(P_ACT, '0, 2'h3, 1'b1, 2);
    cmd(P_NOP, '0, 2'h0, 1'b0, 3);
    rreg(OFS_STATUS, 32'h804, "act pd");
    cmd(P_NOP, '0, 2'h0, 1'b1, 2);
    cmd(P_PRE, A_ALL, 2'h0, 1'b1, 3);
    cmd(P_REF, '0, 2'h0, 1'b0, 3);
    rreg(OFS_STATUS, 32'h8, "self ref");
    cmd(P_NOP, '0, 2'h0, 1'b1, 4);
    rreg(OFS_STATUS, 32'h1, "sr exit");
    $display("done power");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // reset for 20 cycles, then the scenarios in turn
  initial begin
    sys_rst_in = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_be = 4'h0;
    avs_wdata = 32'h0;
    repeat (20) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_decode();
    t_burst();
    t_trunc();
    t_turn();
    t_pwr();
    wrap_up();
  end
endmodule // ddr_cmd_state_test
